/* core/deser_output_port.sv */
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "deser_out_params.svh"

// Overview of operation
// R1: data bits 7:0 red, 15:8 green, 23:16 blue
// R2: data pins sampled as straps at power-up
// R3: power-down drives outputs to sleep-selected state
// R4: first control de, second hsync, third vsync
// R5: filter on: de/hsync need three stable clocks
// R6: filter off: no minimum width on de/hsync
// R7: source toggles de/hsync at most twice/130
// R8: source toggles vsync at most once/130
// R9: vsync handled identically in every mode
// R10: outputs launched relative to selected strobe edge
// R11: select high strobes rising, low falling
// R12: lock high when locked, else sleep state
// R13: self-test pass drops on any payload error
// R14: mode strap 00 off, 01 filter, 1x compat
// R15: low band when bit 1, else high band
// R16: band bit ignored without spread spectrum
// R17: registers may override strobe edge and band
module deser_output_port
   import deser_out_pkg::*;
#(
   parameter int unsigned FILT_CLKS = `DOP_FILT_CLKS,
   parameter int unsigned STRAP_CYC =
      (`DOP_STRAP_NS + `DOP_SYS_PERIOD_NS - 1) / `DOP_SYS_PERIOD_NS
) (
   // system clock, reset and enable
   input  wire logic        clk_sys_i,
   input  wire logic        rst_i,
   input  wire logic        ce_i,
   // register port
   input  wire logic [7:0]  reg_addr_i,
   input  wire logic [31:0] reg_wdata_i,
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   output logic      [31:0] reg_rdata_o,
   // link side
   input  wire logic        clk_link_i,
   input  wire pixel_s      pixel_i,
   input  wire logic        pll_locked_i,
   input  wire logic        bist_err_i,
   // control pins
   input  wire logic        power_down_n_i,
   input  wire logic        bist_enable_i,
   // shared data and strap pins
   input  wire logic [23:0] data_i,
   output logic      [23:0] data_o,
   output logic             data_oe_o,
   // control, clock and status pins
   output logic             ctrl_out_de_o,
   output logic             ctrl_out_hsync_o,
   output logic             ctrl_out_vsync_o,
   output logic             recovered_pixel_clk_o,
   output logic             out_oe_o,
   output logic             lock_o,
   output logic             pass_o,
   output logic             spread_spectrum_clocking_o,
   output logic             spread_low_band_o
);

   // =======================================================================
   // system domain: pin synchronisers and strap capture
   logic [23:0]  pin_m_q;
   logic [23:0]  pin_s_q;
   strap_state_e st_q;
   logic [15:0]  strap_cnt_q;
   logic [1:0]   strap_mode_q;
   logic         strap_lf_q;
   logic         strap_oss_q;
   logic         strap_edge_q;
   logic         strap_ssc_q;
   logic         strap_done;

   // two flops before anything looks at the pins
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         pin_m_q <= 24'h000000;
         pin_s_q <= 24'h000000;
      end else if (ce_i) begin
         pin_m_q <= data_i;
         pin_s_q <= pin_m_q;
      end
   end

   // pins stay inputs for a settle time, then the straps are latched once
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         st_q         <= ST_SAMPLE;
         strap_cnt_q  <= 16'h0000;
         strap_mode_q <= 2'h0;
         strap_lf_q   <= 1'b0;
         strap_oss_q  <= 1'b0;
         strap_edge_q <= 1'b0;
         strap_ssc_q  <= 1'b0;
      end else if (ce_i) begin
         case (st_q)
            ST_SAMPLE: begin
               if (strap_cnt_q == 16'(STRAP_CYC - 1)) begin
                  st_q         <= ST_RUN;
                  strap_mode_q <= {pin_s_q[`DOP_PIN_CFG1], pin_s_q[`DOP_PIN_CFG0]}; // R2 R14
                  strap_lf_q   <= pin_s_q[`DOP_PIN_LF]; // R2
                  strap_oss_q  <= pin_s_q[`DOP_PIN_OSS];
                  strap_edge_q <= pin_s_q[`DOP_PIN_EDGE];
                  strap_ssc_q  <= |pin_s_q[`DOP_PIN_SSC_HI:`DOP_PIN_SSC_LO];
               end else begin
                  strap_cnt_q <= strap_cnt_q + 16'h0001;
               end
            end
            ST_RUN:  st_q <= ST_RUN;
            default: st_q <= ST_SAMPLE;
         endcase
      end
   end
   assign strap_done = (st_q == ST_RUN);

   // =======================================================================
   // system domain: registers
   logic [5:0]  ctrl_q;
   cfg_s        cfg_d;
   cfg_s        cfg_q;
   logic        lock_m_q;
   logic        lock_s_q;
   logic        pass_m_q;
   logic        pass_s_q;
   logic [31:0] rdata_d;

   // software overrides of the strapped settings
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         ctrl_q <= `DOP_CTRL_RST;
      end else if (ce_i && reg_wr_i && reg_addr_i == `DOP_ADDR_CTRL) begin
         ctrl_q <= reg_wdata_i[5:0];
      end
   end

   // effective configuration; band only matters with spread spectrum on
   always_comb begin
      cfg_d             = '0;
      cfg_d.mode        = strap_mode_q;
      cfg_d.spread_en   = strap_ssc_q;
      cfg_d.strobe_rise = ctrl_q[`DOP_CTRL_EDGE_OVR] ? ctrl_q[`DOP_CTRL_EDGE_VAL] : strap_edge_q; // R17
      cfg_d.sleep_sel   = ctrl_q[`DOP_CTRL_OSS_OVR] ? ctrl_q[`DOP_CTRL_OSS_VAL] : strap_oss_q;
      cfg_d.low_band    = strap_ssc_q &
                          (ctrl_q[`DOP_CTRL_LF_OVR] ? ctrl_q[`DOP_CTRL_LF_VAL] : strap_lf_q); // R15 R16 R17
   end

   // registered so the crossing sees glitch-free levels
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         cfg_q                      <= '0;
         spread_spectrum_clocking_o <= 1'b0;
         spread_low_band_o          <= 1'b0;
      end else if (ce_i) begin
         cfg_q                      <= cfg_d;
         spread_spectrum_clocking_o <= cfg_d.spread_en;
         spread_low_band_o          <= cfg_d.low_band; // R15 R16
      end
   end

   // link status back into the system domain
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         lock_m_q <= 1'b0;
         lock_s_q <= 1'b0;
         pass_m_q <= 1'b0;
         pass_s_q <= 1'b0;
      end else if (ce_i) begin
         lock_m_q <= lock_o;
         lock_s_q <= lock_m_q;
         pass_m_q <= pass_o;
         pass_s_q <= pass_m_q;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      rdata_d = 32'h00000000;
      case (reg_addr_i)
         `DOP_ADDR_CTRL: rdata_d[5:0] = ctrl_q;
         `DOP_ADDR_STATUS: begin
            rdata_d[`DOP_STAT_LOCK] = lock_s_q;
            rdata_d[`DOP_STAT_PASS] = pass_s_q;
            rdata_d[`DOP_STAT_DONE] = strap_done;
            rdata_d[`DOP_STAT_EDGE] = cfg_q.strobe_rise;
            rdata_d[`DOP_STAT_LF]   = cfg_q.low_band;
            rdata_d[`DOP_STAT_OSS]  = cfg_q.sleep_sel;
            rdata_d[`DOP_STAT_SSC]  = cfg_q.spread_en;
            rdata_d[`DOP_STAT_MODE_HI:`DOP_STAT_MODE_LO] = cfg_q.mode;
         end
         `DOP_ADDR_STRAP: rdata_d[23:0] = pin_s_q;
         default:         rdata_d = 32'h00000000;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge clk_sys_i) begin
      if (rst_i) begin
         reg_rdata_o <= 32'h00000000;
      end else if (ce_i) begin
         reg_rdata_o <= reg_rd_i ? rdata_d : 32'h00000000;
      end
   end

   // =======================================================================
   // link domain: crossings
   logic lrst_m_q;
   logic lrst_q;
   logic ce_m_q;
   logic ce_l_q;
   cfg_s cfg_m_q;
   cfg_s cfg_sync_q;
   cfg_s cfg_hold_q;
   cfg_s cfg_l_q;
   logic done_m_q;
   logic done_l_q;
   logic pd_m_q;
   logic pd_l_q;
   logic lk_m_q;
   logic lk_l_q;
   logic be_m_q;
   logic be_l_q;

   // reset synchroniser; no reset of its own by nature
   always_ff @(posedge clk_link_i) begin
      lrst_m_q <= rst_i;
      lrst_q   <= lrst_m_q;
   end

   // quasi-static levels, two flops each; the configuration word passes four and is taken once stable
   always_ff @(posedge clk_link_i) begin
      if (lrst_q) begin
         ce_m_q   <= 1'b0;
         ce_l_q   <= 1'b0;
         cfg_m_q    <= '0;
         cfg_sync_q <= '0;
         cfg_hold_q <= '0;
         cfg_l_q    <= '0;
         done_m_q <= 1'b0;
         done_l_q <= 1'b0;
         pd_m_q   <= 1'b0;
         pd_l_q   <= 1'b0;
         lk_m_q   <= 1'b0;
         lk_l_q   <= 1'b0;
         be_m_q   <= 1'b0;
         be_l_q   <= 1'b0;
      end else begin
         ce_m_q   <= ce_i;
         ce_l_q   <= ce_m_q;
         cfg_m_q    <= cfg_q;
         cfg_sync_q <= cfg_m_q;
         cfg_hold_q <= cfg_sync_q;
         cfg_l_q    <= (cfg_sync_q == cfg_hold_q) ? cfg_hold_q : cfg_l_q; // word taken only once it stops moving
         done_m_q <= strap_done;
         done_l_q <= done_m_q;
         pd_m_q   <= power_down_n_i;
         pd_l_q   <= pd_m_q;
         lk_m_q   <= pll_locked_i;
         lk_l_q   <= lk_m_q;
         be_m_q   <= bist_enable_i;
         be_l_q   <= be_m_q;
      end
   end

   // =======================================================================
   // link domain: pixel clock and launch
   logic  phase_q;
   logic  launch;
   logic  active;
   logic  filt_on;
   logic  [1:0] raw_ctrl;
   logic  [1:0] filt_q;

   // pixel clock is half the link clock; data launch on the far edge
   assign launch  = ~phase_q;
   assign active  = pd_l_q & lk_l_q & done_l_q;
   assign filt_on = (cfg_l_q.mode == MODE_FILT_ON); // R14
   assign raw_ctrl = {pixel_i.ctrl.hsync, pixel_i.ctrl.de};

   always_ff @(posedge clk_link_i) begin
      if (lrst_q) begin
         phase_q               <= 1'b0;
         recovered_pixel_clk_o <= 1'b0;
      end else if (ce_l_q) begin
         phase_q <= ~phase_q;
         if (!active) begin
            recovered_pixel_clk_o <= 1'b0; // R3 R12
         end else if (launch) begin
            recovered_pixel_clk_o <= ~cfg_l_q.strobe_rise; // R10 R11
         end else begin
            recovered_pixel_clk_o <= cfg_l_q.strobe_rise; // R11
         end
      end
   end

   // per-signal glitch filter for de and hsync
   for (genvar g = 0; g < 2; g++) begin : g_filt
      logic [1:0] cnt_q;
      logic       level_q;
      assign filt_q[g] = level_q;
      always_ff @(posedge clk_link_i) begin
         if (lrst_q) begin
            cnt_q   <= 2'h0;
            level_q <= 1'b0;
         end else if (ce_l_q && launch) begin
            if (!filt_on || raw_ctrl[g] == level_q) begin
               cnt_q   <= 2'h0;
               level_q <= raw_ctrl[g]; // R6
            end else if (cnt_q == 2'(FILT_CLKS - 1)) begin
               cnt_q   <= 2'h0;
               level_q <= raw_ctrl[g]; // R5
            end else begin
               cnt_q <= cnt_q + 2'h1;
            end
         end
      end
   end

   // output stage; sleep state is driven low or released
   always_ff @(posedge clk_link_i) begin
      if (lrst_q) begin
         data_o           <= 24'h000000;
         data_oe_o        <= 1'b0;
         ctrl_out_de_o    <= 1'b0;
         ctrl_out_hsync_o <= 1'b0;
         ctrl_out_vsync_o <= 1'b0;
         out_oe_o         <= 1'b0;
         lock_o           <= 1'b0;
      end else if (ce_l_q) begin
         lock_o <= active; // R12
         if (!done_l_q) begin
            data_oe_o <= 1'b0; // R2
            out_oe_o  <= 1'b0;
         end else if (!active) begin
            data_o           <= 24'h000000; // R3 R12
            ctrl_out_de_o    <= 1'b0;
            ctrl_out_hsync_o <= 1'b0;
            ctrl_out_vsync_o <= 1'b0;
            data_oe_o        <= ~cfg_l_q.sleep_sel;
            out_oe_o         <= ~cfg_l_q.sleep_sel;
         end else if (launch) begin
            data_o           <= pixel_i.data; // R1
            ctrl_out_de_o    <= filt_on ? filt_q[0] : pixel_i.ctrl.de; // R4
            ctrl_out_hsync_o <= filt_on ? filt_q[1] : pixel_i.ctrl.hsync; // R4
            ctrl_out_vsync_o <= pixel_i.ctrl.vsync; // R9
            data_oe_o        <= 1'b1;
            out_oe_o         <= 1'b1;
         end
      end
   end

   // self-test pass flag; an error wins while self-test is enabled
   always_ff @(posedge clk_link_i) begin
      if (lrst_q) begin
         pass_o <= 1'b1;
      end else if (ce_l_q) begin
         if (be_l_q && bist_err_i) begin
            pass_o <= 1'b0; // R13
         end else if (!be_l_q) begin
            pass_o <= 1'b1;
         end
      end
   end

   // =======================================================================
   // checks
   a_strap_oe_off: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R2
      (ce_l_q && !done_l_q) |=> !data_oe_o) else $error("data pins driven before straps taken");
   a_sleep_low: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R3
      (ce_l_q && done_l_q && !pd_l_q && !cfg_l_q.sleep_sel) |=> (data_o == 24'h000000 && data_oe_o))
      else $error("power-down sleep state not driven low");
   a_lock_drop: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R12
      (ce_l_q && !lk_l_q) |=> (!lock_o && !ctrl_out_de_o)) else $error("lock or de high while unlocked");
   a_filter_hold: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R5
      (ce_l_q && launch && filt_on && raw_ctrl[0] != filt_q[0] && g_filt[0].cnt_q != 2'(FILT_CLKS - 1))
      |=> $stable(filt_q[0])) else $error("filtered de changed too early");
   a_nofilt_pass: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R6
      (ce_l_q && active && launch && !filt_on) |=> ctrl_out_hsync_o == $past(pixel_i.ctrl.hsync))
      else $error("unfiltered hsync not passed through");
   a_vsync_pass: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R9
      (ce_l_q && active && launch) |=> ctrl_out_vsync_o == $past(pixel_i.ctrl.vsync))
      else $error("vsync not passed in this mode");
   a_color_map: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R1
      (ce_l_q && active && launch) |=> data_o[23:16] == $past(pixel_i.data[23:16]))
      else $error("blue component misplaced");
   a_strobe_edge: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R11
      (ce_l_q && active && launch) |=> recovered_pixel_clk_o != $past(cfg_l_q.strobe_rise))
      else $error("pixel clock at wrong level on launch");
   a_pass_drop: assert property (@(posedge clk_link_i) disable iff (lrst_q) // R13
      (ce_l_q && be_l_q && bist_err_i) |=> !pass_o ##1 (!pass_o || !$past(be_l_q)))
      else $error("pass flag not dropped");
   a_band_ignore: assert property (@(posedge clk_sys_i) disable iff (rst_i) // R16
      (ce_i && !strap_ssc_q) |=> !spread_low_band_o) else $error("band set without spread spectrum");

endmodule : deser_output_port
`default_nettype wire

/* include/deser_out_params.svh */
`ifndef DESER_OUT_PARAMS_SVH
`define DESER_OUT_PARAMS_SVH

// ==========================================================================
// register map (byte addresses)
`define DOP_ADDR_CTRL     8'h00
`define DOP_ADDR_STATUS   8'h04
`define DOP_ADDR_STRAP    8'h08

// control register bits
`define DOP_CTRL_EDGE_OVR 0
`define DOP_CTRL_EDGE_VAL 1
`define DOP_CTRL_LF_OVR   2
`define DOP_CTRL_LF_VAL   3
`define DOP_CTRL_OSS_OVR  4
`define DOP_CTRL_OSS_VAL  5
`define DOP_CTRL_RST      6'h00

// status register bits
`define DOP_STAT_LOCK     0
`define DOP_STAT_PASS     1
`define DOP_STAT_DONE     2
`define DOP_STAT_EDGE     3
`define DOP_STAT_LF       4
`define DOP_STAT_OSS      5
`define DOP_STAT_SSC      6
`define DOP_STAT_MODE_LO  8
`define DOP_STAT_MODE_HI  9

// strap positions on the shared data pins
`define DOP_PIN_CFG1      22
`define DOP_PIN_CFG0      23
`define DOP_PIN_LF        20
`define DOP_PIN_OSS       18
`define DOP_PIN_EDGE      17
`define DOP_PIN_SSC_HI    6
`define DOP_PIN_SSC_LO    3

// timing
`define DOP_SYS_PERIOD_NS 10
`define DOP_STRAP_NS      1000
`define DOP_FILT_CLKS     3

`endif

/* include/deser_out_pkg.sv */
package deser_out_pkg;

   // ========================================================================
   // control outputs as they travel together
   typedef struct packed {
      logic vsync;
      logic hsync;
      logic de;
   } ctrl_s;

   // one decoded pixel word from the serial path
   typedef struct packed {
      logic [23:0] data;
      ctrl_s       ctrl;
   } pixel_s;

   // effective configuration handed to the link side
   typedef struct packed {
      logic       strobe_rise;
      logic       low_band;
      logic       sleep_sel;
      logic       spread_en;
      logic [1:0] mode;
   } cfg_s;

   // control strap decode
   typedef enum logic [1:0] {
      MODE_FILT_OFF = 2'h0,
      MODE_FILT_ON  = 2'h1,
      MODE_COMPAT_A = 2'h2,
      MODE_COMPAT_B = 2'h3
   } mode_e;

   // strap sampling sequence
   typedef enum logic [1:0] {
      ST_SAMPLE = 2'h1,
      ST_RUN    = 2'h2
   } strap_state_e;

endpackage : deser_out_pkg

/* test/pixel_source.sv */
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// far side: link pixel source plus the strap resistors on the shared pins
module pixel_source
   import deser_out_pkg::*;
(
   // link clock
   input  wire logic        clk_link_i,
   // shared data pins
   input  wire logic [23:0] strap_i,
   input  wire logic [23:0] pin_out_i,
   input  wire logic        pin_oe_i,
   output logic      [23:0] pin_in_o,
   // link payload
   output var pixel_s       pixel_o,
   output logic             bist_err_o
);

   // released pins fall to their pull level, never to the last driven value
   assign pin_in_o = pin_oe_i ? pin_out_i : strap_i;

   initial begin
      pixel_o    = '0;
      bist_err_o = 1'b0;
   end

   // hold one pixel word for n link cycles, changed just after an edge
   task automatic send(input pixel_s p, input int n);
      @(posedge clk_link_i);
      pixel_o <= p;
      repeat (n - 1) @(posedge clk_link_i);
   endtask : send

   // control pulse of clks pixel clocks, then a quiet stretch of 130 clocks
   task automatic pulse(input logic [2:0] bits, input int clks);
      pixel_s p;
      p      = pixel_o;
      p.ctrl = p.ctrl ^ bits;
      send(p, 2 * clks);
      p.ctrl = p.ctrl ^ bits;
      send(p, 260);
   endtask : pulse

   // single payload error pulse
   task automatic err();
      @(posedge clk_link_i);
      bist_err_o <= 1'b1;
      @(posedge clk_link_i);
      bist_err_o <= 1'b0;
   endtask : err

endmodule : pixel_source

`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "deser_out_params.svh"

module tb_top
   import deser_out_pkg::*;
;
   // ========================================================================
   // stimulus and observed signals
   logic        clk_sys_i = 0, clk_link_i = 0, rst_i = 1, reg_wr_i = 0, reg_rd_i = 0;
   logic        pll_locked_i = 1, power_down_n_i = 1, bist_enable_i = 0;
   logic [7:0]  reg_addr_i = 8'h00;
   logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, rng_q = 32'h638e, rd_q;
   pixel_s      pixel_i, p;
   logic        bist_err_i, data_oe_o, out_oe_o, lock_o, pass_o, ssc_o, band_o, pclk_o;
   logic        de_o, hs_o, vs_o, edge_chk = 0, exp_rise = 0;
   logic [23:0] data_i, data_o, strap_q = 24'h0, last_d = 24'h0;
   logic [2:0]  seen_q = 3'h0;
   logic [5:0]  ctrl_q;
   int          fail_count = 0, n_compared = 0, cyc_q = 0;

   deser_output_port #(.STRAP_CYC(4)) u_dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(1'b1),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
      .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .clk_link_i(clk_link_i), .pixel_i(pixel_i), .pll_locked_i(pll_locked_i),
      .bist_err_i(bist_err_i), .power_down_n_i(power_down_n_i), .bist_enable_i(bist_enable_i),
      .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
      .ctrl_out_de_o(de_o), .ctrl_out_hsync_o(hs_o), .ctrl_out_vsync_o(vs_o),
      .recovered_pixel_clk_o(pclk_o), .out_oe_o(out_oe_o), .lock_o(lock_o), .pass_o(pass_o),
      .spread_spectrum_clocking_o(ssc_o), .spread_low_band_o(band_o));

   pixel_source u_src (
      .clk_link_i(clk_link_i), .strap_i(strap_q), .pin_out_i(data_o), .pin_oe_i(data_oe_o),
      .pin_in_o(data_i), .pixel_o(pixel_i), .bist_err_o(bist_err_i));

   // ========================================================================
   // clocks; link phase offset so the two domains never line up
   initial forever #5 clk_sys_i = ~clk_sys_i;
   initial begin
      #3.7;
      forever #24 clk_link_i = ~clk_link_i;
   end

   // ========================================================================
   // helpers
   function automatic logic [31:0] rnd();
      rng_q = rng_q ^ (rng_q << 13);
      rng_q = rng_q ^ (rng_q >> 17);
      rng_q = rng_q ^ (rng_q << 5);
      return rng_q;
   endfunction : rnd

   // band only counts while spread is on; register bits override straps
   function automatic logic [31:0] exp_status(input logic [23:0] s, input logic [5:0] c);
      logic ssc;
      ssc = |s[6:3];
      return {22'h0, s[22], s[23], 1'b0, ssc, c[4] ? c[5] : s[18],
              ssc & (c[2] ? c[3] : s[20]), c[0] ? c[1] : s[17], 3'b111};
   endfunction : exp_status

   task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk_word

   task automatic chk_bit(input string nm, input logic e, input logic g);
      n_compared++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %b seen %b", nm, e, g);
      end
   endtask : chk_bit

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : stop_test

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      reg_addr_i  <= a;
      reg_wdata_i <= d;
      reg_wr_i    <= 1'b1;
      @(posedge clk_sys_i);
      reg_wr_i    <= 1'b0;
   endtask : reg_wr

   // read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
      @(posedge clk_sys_i);
      reg_addr_i <= a;
      reg_rd_i   <= 1'b1;
      @(posedge clk_sys_i);
      reg_rd_i   <= 1'b0;
      #1 chk_word(nm, e, reg_rdata_o);
   endtask : rd_chk

   task automatic wait_lock();
      for (int i = 0; i < 400 && lock_o !== 1'b1; i++) @(posedge clk_sys_i);
      #1 chk_bit("lock_o", 1'b1, lock_o);
   endtask : wait_lock

   task automatic do_reset();
      @(posedge clk_sys_i);
      rst_i <= 1'b1;
      repeat (20) @(posedge clk_sys_i); // long enough for the link side too
      rst_i <= 1'b0;
      @(posedge clk_sys_i);
      #1 chk_bit("data_oe_o", 1'b0, data_oe_o);
      wait_lock();
   endtask : do_reset

   task automatic pulse_chk(input logic [2:0] bits, input int clks, input logic [2:0] e);
      seen_q = 3'h0;
      u_src.pulse(bits, clks);
      chk_word("ctrl seen", {29'h0, e}, {29'h0, seen_q});
   endtask : pulse_chk

   // ========================================================================
   // link side monitors: control activity and strobe edge at each data change
   always @(negedge clk_link_i) seen_q <= seen_q | {vs_o, hs_o, de_o};
   always @(posedge clk_link_i) begin
      #1;
      if (edge_chk && data_o !== last_d) chk_bit("pixel clk", ~exp_rise, pclk_o);
      last_d = data_o;
   end

   // hang guard
   always @(posedge clk_sys_i) begin
      cyc_q++;
      if (cyc_q == 60000) begin
         fail_count++;
         stop_test();
      end
   end

   // ========================================================================
   // main sequence
   initial begin
      repeat (8) @(posedge clk_sys_i);
      for (int i = 0; i < 6; i++) begin
         rd_q    = rnd();
         strap_q = 24'h0;
         {strap_q[22], strap_q[23]} = 2'(i % 4);
         {strap_q[20], strap_q[18], strap_q[17]} = rd_q[2:0];
         strap_q[6:3] = rd_q[3] ? rd_q[7:4] : 4'h0;
         edge_chk = 1'b0;
         do_reset();
         ctrl_q = rd_q[13:8];
         reg_wr(`DOP_ADDR_CTRL, {26'h0, ctrl_q});
         reg_wr(8'h10, rnd());
         rd_chk(`DOP_ADDR_CTRL, {26'h0, ctrl_q}, "ctrl reg");
         rd_chk(8'h0c, 32'h0, "unmapped");
         rd_chk(`DOP_ADDR_STATUS, exp_status(strap_q, ctrl_q), "status");
         chk_bit("spread", |strap_q[6:3], ssc_o);
         rd_q = exp_status(strap_q, ctrl_q);
         chk_bit("band", rd_q[4], band_o);
         exp_rise = ctrl_q[0] ? ctrl_q[1] : strap_q[17];
         for (int k = 0; k < 4; k++) begin
            p = '0;
            p.data = rnd();
            u_src.send(p, 12);
            edge_chk = 1'b1;
            @(negedge clk_link_i);
            chk_word("data_o", {8'h0, p.data}, {8'h0, data_o});
            chk_bit("data_oe_o", 1'b1, data_oe_o);
            chk_bit("out_oe_o", 1'b1, out_oe_o);
         end
         case (i % 4)
            0: pulse_chk(3'b010, 1, 3'b010);
            1: begin
               pulse_chk(3'b001, 1, 3'b000);
               pulse_chk(3'b010, 3, 3'b010);
               pulse_chk(3'b100, 130, 3'b100);
            end
            default: pulse_chk(3'b001, 1, 3'b001);
         endcase
      end
      edge_chk = 1'b0;
      // power down and loss of lock, each with both sleep states
      for (int k = 0; k < 4; k++) begin
         reg_wr(`DOP_ADDR_CTRL, {26'h0, k[0], 1'b1, 4'h0});
         @(posedge clk_sys_i);
         if (k[1]) power_down_n_i <= 1'b0;
         else pll_locked_i <= 1'b0;
         repeat (60) @(posedge clk_sys_i);
         #1 chk_word("sleep pins", {~k[0], ~k[0], 30'h0},
                     {data_oe_o, out_oe_o, lock_o, de_o, hs_o, vs_o, pclk_o, 1'b0, data_o});
         // released pins must read back as the strap levels
         if (k[0]) rd_chk(`DOP_ADDR_STRAP, {8'h0, strap_q}, "strap pins");
         @(posedge clk_sys_i);
         power_down_n_i <= 1'b1;
         pll_locked_i   <= 1'b1;
         wait_lock();
      end
      // self test pass flag
      @(posedge clk_sys_i);
      bist_enable_i <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      #1 chk_bit("pass_o", 1'b1, pass_o);
      u_src.err();
      repeat (40) @(posedge clk_sys_i);
      #1 chk_bit("pass_o", 1'b0, pass_o);
      @(posedge clk_sys_i);
      bist_enable_i <= 1'b0;
      repeat (40) @(posedge clk_sys_i);
      #1 chk_bit("pass_o", 1'b1, pass_o);
      stop_test();
   end

endmodule : tb_top

`default_nettype wire
